// File: rtl/rps_pkg.sv
// shared constants for the remappable pin select block
package rps_pkg;
	// register byte offsets on the register bus
	localparam logic [7:0] RPS_IRQ1_ROUTE_OFS  = 8'h00;
	localparam logic [7:0] RPS_PIN5657_OFS     = 8'h04;
	// field positions
	localparam int         RPS_IRQ1_CODE_LSB   = 8;
	localparam int         RPS_IRQ1_CODE_W     = 7;
	localparam int         RPS_PIN57_CODE_LSB  = 8;
	localparam int         RPS_PIN56_CODE_LSB  = 0;
	localparam int         RPS_FN_CODE_W       = 6;
	// reset values
	localparam logic [6:0] RPS_IRQ1_CODE_RST   = 7'h00;
	localparam logic [5:0] RPS_FN_CODE_RST     = 6'h00;
	// input source codes
	localparam logic [6:0] RPS_SRC_TIED_LOW    = 7'h00;
	localparam logic [6:0] RPS_SRC_COMPARATOR1 = 7'h01;
	localparam logic [6:0] RPS_SRC_PIN_121     = 7'h79;
	// output function code that leaves the pin to its port latch
	localparam logic [5:0] RPS_FN_PORT_CTRL    = 6'h00;
	// bus responses
	localparam logic [1:0] RPS_RESP_OKAY       = 2'h0;
	localparam logic [1:0] RPS_RESP_SLVERR     = 2'h2;
endpackage

// File: rtl/rps_route_if.sv
// selection codes passed from the register file to the routing logic
`timescale 1ns/100ps
interface rps_route_if;
	logic [6:0] ext_irq1_source_code;
	logic [5:0] pin56_function_code;
	logic [5:0] pin57_function_code;
	modport regs (output ext_irq1_source_code, output pin56_function_code,
		output pin57_function_code);
	modport core (input ext_irq1_source_code, input pin56_function_code,
		input pin57_function_code);
endinterface

// File: rtl/rps_route_core.sv
// input and output routing multiplexers, all outputs registered
`timescale 1ns/100ps
module rps_route_core
	import rps_pkg::*;
#(
	parameter int NUM_IN = 128,
	parameter int NUM_FN = 64
) (
	input  wire logic              sys_clk,
	input  wire logic              reset_n,
	rps_route_if.core              route,
	input  wire logic              comparatorOneOutput,
	input  wire logic [NUM_IN-1:0] remapPinIn,
	input  wire logic [NUM_FN-1:0] periphFuncOut,
	input  wire logic [1:0]        portLatch,
	output logic                   externalIrq1,
	output logic [1:0]             remapPinOut,
	output logic [1:0]             remapPinDriven
);
	// pick one peripheral function bit by its code
	function automatic logic fnPick(input logic [5:0] code, input logic [NUM_FN-1:0] fn);
		fnPick = fn[code];
	endfunction

	logic       irq_reg;
	logic       irq_next;
	logic [1:0] pinOut_reg;
	logic [1:0] pinOut_next;
	logic [1:0] pinDrv_reg;
	logic [1:0] pinDrv_next;
	logic [5:0] fnCode [2];
	logic [1:0] fnSel;

	assign fnCode[0] = route.pin56_function_code;
	assign fnCode[1] = route.pin57_function_code;

	// interrupt source select
	always_comb begin
		case (route.ext_irq1_source_code)
			RPS_SRC_TIED_LOW:    irq_next = 1'b0;
			RPS_SRC_COMPARATOR1: irq_next = comparatorOneOutput;
			default:             irq_next = remapPinIn[route.ext_irq1_source_code];
		endcase
	end

	// one output slot per remappable pin
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gPin
			assign fnSel[g] = fnPick(fnCode[g], periphFuncOut);
			always_comb begin
				if (fnCode[g] == RPS_FN_PORT_CTRL) begin
					pinOut_next[g] = portLatch[g];
					pinDrv_next[g] = 1'b0;
				end else begin
					pinOut_next[g] = fnSel[g];
					pinDrv_next[g] = 1'b1;
				end
			end
		end
	endgenerate

	// registered so pins never see mux glitches, at one cycle of latency
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_reg    <= 1'b0;
			pinOut_reg <= 2'h0;
			pinDrv_reg <= 2'h0;
		end else begin
			irq_reg    <= irq_next;
			pinOut_reg <= pinOut_next;
			pinDrv_reg <= pinDrv_next;
		end
	end

	assign externalIrq1   = irq_reg;
	assign remapPinOut    = pinOut_reg;
	assign remapPinDriven = pinDrv_reg;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	a_irq_tied_low: assert property (
		route.ext_irq1_source_code == RPS_SRC_TIED_LOW |=> !externalIrq1)
		else $error("interrupt not low for code zero");
	a_irq_comp_feed: assert property (
		route.ext_irq1_source_code == RPS_SRC_COMPARATOR1
		|=> externalIrq1 == $past(comparatorOneOutput))
		else $error("interrupt not following comparator");
	a_irq_pin_121: assert property (
		route.ext_irq1_source_code == RPS_SRC_PIN_121
		|=> externalIrq1 == $past(remapPinIn[121]))
		else $error("interrupt not following pin 121");
	a_pin56_function: assert property (
		route.pin56_function_code != RPS_FN_PORT_CTRL
		|=> remapPinDriven[0] && remapPinOut[0] == $past(fnSel[0]))
		else $error("pin 56 not driven by chosen function");
	a_pin57_function: assert property (
		route.pin57_function_code != RPS_FN_PORT_CTRL
		|=> remapPinDriven[1] && remapPinOut[1] == $past(fnSel[1]))
		else $error("pin 57 not driven by chosen function");
	a_pin_port_ctrl: assert property (
		route.pin56_function_code == RPS_FN_PORT_CTRL
		|=> !remapPinDriven[0] && remapPinOut[0] == $past(portLatch[0]))
		else $error("pin 56 not under port control");
	c_irq_comp: cover property (route.ext_irq1_source_code == RPS_SRC_COMPARATOR1 ##1 externalIrq1);
	c_pin57_on: cover property (remapPinDriven[1] && remapPinOut[1]);
endmodule

// File: rtl/rps_remappable_pin_select.sv
// remappable pin select: register file on the register bus plus routing
`timescale 1ns/100ps
module rps_remappable_pin_select
	import rps_pkg::*;
#(
	parameter int NUM_IN = 128,
	parameter int NUM_FN = 64
) (
	input  wire logic              sys_clk,
	input  wire logic              reset_n,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              comparatorOneOutput,
	input  wire logic [NUM_IN-1:0] remapPinIn,
	input  wire logic [NUM_FN-1:0] periphFuncOut,
	input  wire logic [1:0]        portLatch,
	output logic                   externalIrq1,
	output logic [1:0]             remapPinOut,
	output logic [1:0]             remapPinDriven
);
	rps_route_if route ();

	logic [6:0]  irqCode_reg;
	logic [6:0]  irqCode_next;
	logic [5:0]  pin56Code_reg;
	logic [5:0]  pin56Code_next;
	logic [5:0]  pin57Code_reg;
	logic [5:0]  pin57Code_next;
	logic        awready_reg;
	logic        awready_next;
	logic        bvalid_reg;
	logic        bvalid_next;
	logic [1:0]  bresp_reg;
	logic [1:0]  bresp_next;
	logic        arready_reg;
	logic        arready_next;
	logic        rvalid_reg;
	logic        rvalid_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [1:0]  rresp_reg;
	logic [1:0]  rresp_next;
	logic        wrFire;
	logic        rdFire;

	// both write channels are taken together in one handshake
	assign wrFire = awready_reg && s_axi_awvalid && s_axi_wvalid;
	assign rdFire = arready_reg && s_axi_arvalid;

	// write side: accept, update fields, answer
	always_comb begin
		irqCode_next   = irqCode_reg;
		pin56Code_next = pin56Code_reg;
		pin57Code_next = pin57Code_reg;
		bvalid_next    = bvalid_reg && !s_axi_bready;
		bresp_next     = bresp_reg;
		// ready only when no answer pending, so one write is under way
		awready_next   = !awready_reg && !bvalid_reg && s_axi_awvalid && s_axi_wvalid;
		if (wrFire) begin
			bvalid_next = 1'b1;
			bresp_next  = RPS_RESP_OKAY;
			case (s_axi_awaddr)
				RPS_IRQ1_ROUTE_OFS: begin
					if (s_axi_wstrb[1]) begin
						irqCode_next = s_axi_wdata[RPS_IRQ1_CODE_LSB +: RPS_IRQ1_CODE_W];
					end
				end
				RPS_PIN5657_OFS: begin
					// pin 57 field in upper lane
					if (s_axi_wstrb[1]) begin
						pin57Code_next = s_axi_wdata[RPS_PIN57_CODE_LSB +: RPS_FN_CODE_W];
					end
					// pin 56 field in lower lane
					if (s_axi_wstrb[0]) begin
						pin56Code_next = s_axi_wdata[RPS_PIN56_CODE_LSB +: RPS_FN_CODE_W];
					end
				end
				default: bresp_next = RPS_RESP_SLVERR;
			endcase
		end
	end

	// read side: capture address, return data next cycle
	always_comb begin
		arready_next = !arready_reg && !rvalid_reg && s_axi_arvalid;
		rvalid_next  = rvalid_reg && !s_axi_rready;
		rdata_next   = rdata_reg;
		rresp_next   = rresp_reg;
		if (rdFire) begin
			rvalid_next = 1'b1;
			rdata_next  = 32'h0000_0000;
			rresp_next  = RPS_RESP_OKAY;
			case (s_axi_araddr)
				RPS_IRQ1_ROUTE_OFS: rdata_next[RPS_IRQ1_CODE_LSB +: RPS_IRQ1_CODE_W] = irqCode_reg;
				RPS_PIN5657_OFS: begin
					rdata_next[RPS_PIN57_CODE_LSB +: RPS_FN_CODE_W] = pin57Code_reg;
					rdata_next[RPS_PIN56_CODE_LSB +: RPS_FN_CODE_W] = pin56Code_reg;
				end
				default: rresp_next = RPS_RESP_SLVERR;
			endcase
		end
	end

	// register stage; all selections reset to zero
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			irqCode_reg   <= RPS_IRQ1_CODE_RST;
			pin56Code_reg <= RPS_FN_CODE_RST;
			pin57Code_reg <= RPS_FN_CODE_RST;
			awready_reg   <= 1'b0;
			bvalid_reg    <= 1'b0;
			bresp_reg     <= RPS_RESP_OKAY;
			arready_reg   <= 1'b0;
			rvalid_reg    <= 1'b0;
			rdata_reg     <= 32'h0000_0000;
			rresp_reg     <= RPS_RESP_OKAY;
		end else begin
			irqCode_reg   <= irqCode_next;
			pin56Code_reg <= pin56Code_next;
			pin57Code_reg <= pin57Code_next;
			awready_reg   <= awready_next;
			bvalid_reg    <= bvalid_next;
			bresp_reg     <= bresp_next;
			arready_reg   <= arready_next;
			rvalid_reg    <= rvalid_next;
			rdata_reg     <= rdata_next;
			rresp_reg     <= rresp_next;
		end
	end

	// bus outputs straight from the registers
	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = awready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	assign route.ext_irq1_source_code = irqCode_reg;
	assign route.pin56_function_code  = pin56Code_reg;
	assign route.pin57_function_code  = pin57Code_reg;

	rps_route_core #(
		.NUM_IN (NUM_IN),
		.NUM_FN (NUM_FN)
	) uCore (
		.sys_clk             (sys_clk),
		.reset_n             (reset_n),
		.route               (route.core),
		.comparatorOneOutput (comparatorOneOutput),
		.remapPinIn          (remapPinIn),
		.periphFuncOut       (periphFuncOut),
		.portLatch           (portLatch),
		.externalIrq1        (externalIrq1),
		.remapPinOut         (remapPinOut),
		.remapPinDriven      (remapPinDriven)
	);

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	a_irq_field_store: assert property (
		wrFire && s_axi_awaddr == RPS_IRQ1_ROUTE_OFS && s_axi_wstrb[1]
		|=> irqCode_reg == $past(s_axi_wdata[14:8]))
		else $error("interrupt source field not stored");
	a_reserved_zero: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:15] == 17'h0_0000 && s_axi_rdata[7:6] == 2'h0)
		else $error("reserved read bits not zero");
	a_write_answer: assert property (
		wrFire |=> s_axi_bvalid ##0 !s_axi_awready)
		else $error("write not answered next cycle");
	a_read_answer: assert property (
		rdFire |=> s_axi_rvalid [*1] ##0 !s_axi_arready)
		else $error("read not answered next cycle");
	a_pin57_store: assert property (
		wrFire && s_axi_awaddr == RPS_PIN5657_OFS && s_axi_wstrb[1]
		|=> pin57Code_reg == $past(s_axi_wdata[13:8]))
		else $error("pin 57 function field not stored");
	a_pin56_store: assert property (
		wrFire && s_axi_awaddr == RPS_PIN5657_OFS && s_axi_wstrb[0]
		|=> pin56Code_reg == $past(s_axi_wdata[5:0]))
		else $error("pin 56 function field not stored");
	// a refused write must leave every selection alone
	a_bad_addr_keep: assert property (
		wrFire && s_axi_awaddr != RPS_IRQ1_ROUTE_OFS && s_axi_awaddr != RPS_PIN5657_OFS
		|=> $stable(irqCode_reg) && $stable(pin56Code_reg) && $stable(pin57Code_reg))
		else $error("unmapped write changed a selection");
	// answers stand until the master takes them, or it would miss them
	a_write_resp_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_read_data_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	c_write_irq: cover property (wrFire && s_axi_awaddr == RPS_IRQ1_ROUTE_OFS);
	c_read_pins: cover property (rdFire && s_axi_araddr == RPS_PIN5657_OFS);
	c_bad_addr: cover property (s_axi_bvalid && s_axi_bresp == RPS_RESP_SLVERR);
endmodule

// File: test/rps_periph_model.sv
// stand-in for the on-chip peripherals and the remappable pins
`timescale 1ns/100ps
module rps_periph_model (
	input  wire logic    flip,
	output logic         comparatorOneOutput,
	output logic [127:0] remapPinIn,
	output logic [63:0]  periphFuncOut,
	output logic [1:0]   portLatch
);
	// only pin 121 high, so a wrong pin index shows as a wrong level
	localparam logic [127:0] PIN_PAT = 128'h0200_0000_0000_0000_0000_0000_0000_0000;
	// odd function codes high, even low
	localparam logic [63:0]  FN_PAT  = 64'hAAAA_AAAA_AAAA_AAAA;
	// flip inverts every source, so a stuck output cannot match both phases
	always_comb begin
		comparatorOneOutput = flip;
		remapPinIn          = flip ? ~PIN_PAT : PIN_PAT;
		periphFuncOut       = flip ? ~FN_PAT : FN_PAT;
		portLatch           = {flip, ~flip};
	end
endmodule

// File: test/rps_remappable_pin_select_bench.sv
// self-checking bench for the remappable pin select block
`timescale 1ns/100ps
`define CHK(a, e) begin checksDone++; if ((a) !== (e)) begin badCount++; \
	$display("ERROR t=%0t got %0h exp %0h", $time, (a), (e)); end end
module rps_remappable_pin_select_bench
	import rps_pkg::*;
;
	typedef struct {
		logic [6:0] irq;
		logic [5:0] p56;
		logic [5:0] p57;
		logic       flip;
		logic       expIrq;
		logic [1:0] expPin;
		logic [1:0] expDrv;
	} rps_row_t;
	// codes and source phase beside the routed levels they must give
	rps_row_t rows [7] = '{
		'{7'h00, 6'h00, 6'h03, 1'b0, 1'b0, 2'b11, 2'b10},
		'{7'h01, 6'h3F, 6'h00, 1'b0, 1'b0, 2'b01, 2'b01},
		'{7'h01, 6'h01, 6'h2A, 1'b1, 1'b1, 2'b10, 2'b11},
		'{7'h79, 6'h00, 6'h00, 1'b1, 1'b0, 2'b10, 2'b00},
		'{7'h79, 6'h15, 6'h3E, 1'b0, 1'b1, 2'b01, 2'b11},
		'{7'h05, 6'h07, 6'h00, 1'b1, 1'b1, 2'b10, 2'b01},
		'{7'h00, 6'h00, 6'h00, 1'b1, 1'b0, 2'b10, 2'b00}};
	logic         sys_clk;
	logic         reset_n;
	logic [7:0]   s_axi_awaddr, s_axi_araddr;
	logic         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0]  s_axi_wdata, s_axi_rdata;
	logic [3:0]   s_axi_wstrb;
	logic [1:0]   s_axi_bresp, s_axi_rresp, remapPinOut, remapPinDriven, portLatch;
	logic         comparatorOneOutput, externalIrq1, flip;
	logic [127:0] remapPinIn;
	logic [63:0]  periphFuncOut;
	logic [1:0]   resp;
	logic [31:0]  rd;
	int           badCount, checksDone, cycles;

	rps_remappable_pin_select dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.comparatorOneOutput(comparatorOneOutput), .remapPinIn(remapPinIn),
		.periphFuncOut(periphFuncOut), .portLatch(portLatch), .externalIrq1(externalIrq1),
		.remapPinOut(remapPinOut), .remapPinDriven(remapPinDriven));

	rps_periph_model model_u (.flip(flip), .comparatorOneOutput(comparatorOneOutput),
		.remapPinIn(remapPinIn), .periphFuncOut(periphFuncOut), .portLatch(portLatch));

	// 25 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", checksDone, badCount);
		if (badCount == 0 && checksDone > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// hang guard, whole run needs well under a thousand cycles
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			badCount++;
			giveVerdict();
		end
	end

	// address and data offered together, each released at its own ready
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
		bit awTaken;
		bit wTaken;
		awTaken = 1'b0;
		wTaken = 1'b0;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// the slave may take either channel first
		do begin
			@(posedge sys_clk);
			if (!awTaken && s_axi_awready === 1'b1) begin
				awTaken = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!wTaken && s_axi_wready === 1'b1) begin
				wTaken = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end while (!(awTaken && wTaken));
		while (s_axi_bvalid !== 1'b1) @(posedge sys_clk);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axiRead(input logic [7:0] a);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1) @(posedge sys_clk);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		flip = 1'b0;
		reset_n = 1'b0;
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		// reset values of both registers
		axiRead(RPS_IRQ1_ROUTE_OFS);
		`CHK(rd, 32'h0000_0000)
		axiRead(RPS_PIN5657_OFS);
		`CHK(rd, 32'h0000_0000)
		$display("reset values done");
		// unused bits written high must read back zero
		foreach (rows[i]) begin
			axiWrite(RPS_IRQ1_ROUTE_OFS, {16'hFFFF, 1'b1, rows[i].irq, 8'hFF});
			axiWrite(RPS_PIN5657_OFS, {16'hFFFF, 2'b11, rows[i].p57, 2'b11, rows[i].p56});
			axiRead(RPS_IRQ1_ROUTE_OFS);
			`CHK(rd, {17'h0, rows[i].irq, 8'h00})
			axiRead(RPS_PIN5657_OFS);
			`CHK(rd, {18'h0, rows[i].p57, 2'b00, rows[i].p56})
			@(posedge sys_clk);
			flip <= rows[i].flip;
			repeat (3) @(posedge sys_clk);
			@(negedge sys_clk);
			`CHK(externalIrq1, rows[i].expIrq)
			`CHK(remapPinOut, rows[i].expPin)
			`CHK(remapPinDriven, rows[i].expDrv)
		end
		$display("routing rows done");
		// unmapped address refused, pin 56/57 register untouched
		axiWrite(8'h08, 32'h0000_7F3F);
		`CHK(resp, RPS_RESP_SLVERR)
		axiRead(8'h08);
		`CHK(resp, RPS_RESP_SLVERR)
		`CHK(rd, 32'h0000_0000)
		axiRead(RPS_PIN5657_OFS);
		`CHK(resp, RPS_RESP_OKAY)
		`CHK(rd, 32'h0000_0000)
		$display("unmapped access done");
		// one byte lane at a time: the other pin field must keep its code
		s_axi_wstrb <= 4'h1;
		axiWrite(RPS_PIN5657_OFS, 32'h0000_2A15);
		`CHK(resp, RPS_RESP_OKAY)
		axiRead(RPS_PIN5657_OFS);
		`CHK(rd, 32'h0000_0015)
		s_axi_wstrb <= 4'h2;
		axiWrite(RPS_PIN5657_OFS, 32'h0000_3F3F);
		`CHK(resp, RPS_RESP_OKAY)
		axiRead(RPS_PIN5657_OFS);
		`CHK(rd, 32'h0000_3F15)
		s_axi_wstrb <= 4'hF;
		$display("byte lane writes done");
		// mid-run reset after a live selection
		axiWrite(RPS_IRQ1_ROUTE_OFS, 32'h0000_0100);
		axiWrite(RPS_PIN5657_OFS, 32'h0000_0301);
		repeat (3) @(posedge sys_clk);
		reset_n <= 1'b0;
		@(negedge sys_clk);
		`CHK(externalIrq1, 1'b0)
		`CHK(remapPinDriven, 2'b00)
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		axiRead(RPS_IRQ1_ROUTE_OFS);
		`CHK(rd, 32'h0000_0000)
		$display("mid-run reset done");
		giveVerdict();
	end
endmodule
